/* File: servo_axis_map_monitor.sv */
// Concurrent checks on the servo data map word port and gear divisor outputs.
`default_nettype none
module servo_axis_map_monitor #(
  parameter logic [15:0] GEAR_DIV_DEFAULT = 16'h0001
) (
  input wire logic             clk_sys_i,
  input wire logic             rst_n_i,
  input wire logic             req_i,
  input wire logic             write_i,
  input wire logic [7:0]       cmd_i,
  input wire logic [15:0]      addr_i,
  input wire logic [15:0]      wdata_i,
  input wire logic             ack_o,
  input wire logic [15:0]      rdata_o,
  input wire logic [7:0]       resp_code_o,
  input wire logic [7:0]       err_code_o,
  input wire logic [2:0][31:0] encoder_pulses_i,
  input wire logic [2:0][15:0] gear_divisor_o
);
  logic [15:0]      enc_high;
  wire logic        mapped = addr_i[15:13] <= 3'h2;
  wire logic [12:0] ofs = addr_i[12:0];

  // High half captured at the low-word read, as the host pairs them
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      enc_high <= 16'h0000;
    end else if (req_i && !write_i && addr_i == 16'h080a) begin
      enc_high <= encoder_pulses_i[0][31:16];
    end
  end

  // ****************************************************
  // Properties
  // ****************************************************
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence s_rd(a);
    req_i && !write_i && addr_i == a;
  endsequence
  sequence s_ro_wr;
    req_i && write_i && mapped && ofs >= 13'h081e && ofs <= 13'h0827;
  endsequence

  property p_ack;
    ack_o == $past(req_i);
  endproperty
  property p_unmapped;
    req_i && !mapped |=> err_code_o == 8'h02 && resp_code_o == $past(cmd_i) + 8'h80;
  endproperty
  property p_param;
    req_i && mapped && ofs <= 13'h0369 |=> err_code_o == 8'h00 && resp_code_o == $past(cmd_i);
  endproperty
  property p_alarm_ro;
    s_ro_wr |=> err_code_o == 8'h04;
  endproperty
  property p_enc_low;
    s_rd(16'h080a) |=> rdata_o == $past(encoder_pulses_i[0][15:0]);
  endproperty
  property p_enc_high;
    s_rd(16'h080b) |=> rdata_o == $past(enc_high);
  endproperty
  property p_gear_wr;
    req_i && write_i && mapped && ofs == 13'h0850
      |=> gear_divisor_o[$past(addr_i[14:13])] == $past(wdata_i);
  endproperty
  property p_gear_hold;
    !(req_i && write_i) |=> $stable(gear_divisor_o);
  endproperty
  property p_gear_reset;
    disable iff (1'b0) !rst_n_i |-> gear_divisor_o == {3{GEAR_DIV_DEFAULT}};
  endproperty
  property p_answer_hold;
    !ack_o |-> $stable(rdata_o) && $stable(err_code_o);
  endproperty

  a_ack: assert property (p_ack) else $error("answer strobe misplaced");
  a_unmapped: assert property (p_unmapped) else $error("bad unmapped answer");
  a_param: assert property (p_param) else $error("parameter word refused");
  a_alarm_ro: assert property (p_alarm_ro) else $error("alarm record writable");
  a_enc_low: assert property (p_enc_low) else $error("encoder low word wrong");
  a_enc_high: assert property (p_enc_high) else $error("encoder high not paired");
  a_gear_wr: assert property (p_gear_wr) else $error("gear divisor not applied");
  a_gear_hold: assert property (p_gear_hold) else $error("gear moved unwritten");
  a_gear_reset: assert property (p_gear_reset) else $error("gear not at default");
  a_answer_hold: assert property (p_answer_hold) else $error("answer moved without ack");
endmodule

bind servo_axis_modbus_register_map servo_axis_map_monitor #(
  .GEAR_DIV_DEFAULT(GEAR_DIV_DEFAULT)
) mon (.clk_sys_i, .rst_n_i, .req_i, .write_i, .cmd_i, .addr_i, .wdata_i, .ack_o, .rdata_o,
  .resp_code_o, .err_code_o, .encoder_pulses_i, .gear_divisor_o);
`default_nettype wire

/* File: servo_axis_map_pkg.sv */
// Constants and address layout of the per-axis servo data map.
// What this block does
// - Each axis has a read/write parameter window at 0000-0369, 2000-2369, 4000-4369.
// - Ten read-only alarm records per axis at 081E-0827, repeated for B and C.
// - Encoder pulse count read as low word 080A and high word 080B.
// - Input levels at 080C and 080D, output state at 080E, all read-only.
// - Position: low word 0810 in single pulses, high 0811 in 10000s.
// - Commanded pulses: low word 0818 in single pulses, high 0819 in 10000s.
// - Following error counter read as low word 0814 and high word 0815.
// - Writing gear divisor or either multiplier takes effect at once.
// - Gear values written by the host are lost at restart.
// - Unknown address answers command plus 80h with error code 02h.
`default_nettype none

package servo_axis_map_pkg;

  // ****************************************************
  // Address layout
  // ****************************************************
  localparam int unsigned          AXES          = 3;
  localparam int unsigned          ALARM_RECORDS = 10;
  localparam logic [2:0]           AXIS_C_SEL    = 3'h2;
  localparam logic [12:0]          PARAM_LAST    = 13'h0369;
  localparam logic [11:0]          PARAM_WORDS   = 12'h36a;
  localparam logic [12:0]          ALARM_FIRST   = 13'h081e;
  localparam logic [12:0]          ALARM_LAST    = 13'h0827;
  localparam logic [12:0]          MONITOR_FIRST = 13'h0806;
  localparam logic [12:0]          MONITOR_LAST  = 13'h0816;

  localparam logic [12:0] OFS_ZERO_U        = 13'h07fd;
  localparam logic [12:0] OFS_ZERO_V        = 13'h07fe;
  localparam logic [12:0] OFS_SPEED         = 13'h0806;
  localparam logic [12:0] OFS_TORQUE        = 13'h0809;
  localparam logic [12:0] OFS_ENC_LOW       = 13'h080a;
  localparam logic [12:0] OFS_ENC_HIGH      = 13'h080b;
  localparam logic [12:0] OFS_IN_LOWER      = 13'h080c;
  localparam logic [12:0] OFS_IN_UPPER      = 13'h080d;
  localparam logic [12:0] OFS_OUT_LEVELS    = 13'h080e;
  localparam logic [12:0] OFS_REF_PULSE     = 13'h080f;
  localparam logic [12:0] OFS_POS_UNITS     = 13'h0810;
  localparam logic [12:0] OFS_POS_TENK      = 13'h0811;
  localparam logic [12:0] OFS_FERR_LOW      = 13'h0814;
  localparam logic [12:0] OFS_FERR_HIGH     = 13'h0815;
  localparam logic [12:0] OFS_CMD_UNITS     = 13'h0818;
  localparam logic [12:0] OFS_CMD_TENK      = 13'h0819;
  localparam logic [12:0] OFS_INERTIA       = 13'h081c;
  localparam logic [12:0] OFS_OVERLOAD      = 13'h081d;
  localparam logic [12:0] OFS_GEAR_DIV      = 13'h0850;
  localparam logic [12:0] OFS_GEAR_MUL1     = 13'h0851;
  localparam logic [12:0] OFS_GEAR_MUL2     = 13'h0852;
  localparam logic [12:0] OFS_GEAR_DIV_HI   = 13'h0853;

  // ****************************************************
  // Encodings and answer codes
  // ****************************************************
  localparam logic signed [31:0] PULSES_PER_HIGH = 32'sh00002710;
  localparam logic [7:0]         ERROR_FLAG      = 8'h80;
  localparam logic [7:0]         ERR_NONE        = 8'h00;
  localparam logic [7:0]         ERR_NO_ADDRESS  = 8'h02;
  localparam logic [7:0]         ERR_NOT_DONE    = 8'h04;

  // Snapshot slots for the high halves of split values
  localparam int unsigned SNAP_ENC  = 0;
  localparam int unsigned SNAP_POS  = 1;
  localparam int unsigned SNAP_FERR = 2;
  localparam int unsigned SNAP_CMD  = 3;

endpackage

`default_nettype wire

/* File: servo_axis_modbus_register_map.sv */
// Three-axis servo data map reached by word requests from the serial protocol engine.
`default_nettype none

module servo_axis_modbus_register_map #(
  parameter logic [15:0] GEAR_DIV_DEFAULT    = 16'h0001,
  parameter logic [15:0] GEAR_MUL1_DEFAULT   = 16'h0001,
  parameter logic [15:0] GEAR_MUL2_DEFAULT   = 16'h0001,
  parameter logic [15:0] GEAR_DIV_HI_DEFAULT = 16'h0000
) (
  input  wire logic             clk_sys_i,
  input  wire logic             rst_n_i,
  // Word request from the frame engine
  input  wire logic             req_i,
  input  wire logic             write_i,
  input  wire logic [7:0]       cmd_i,
  input  wire logic [15:0]      addr_i,
  input  wire logic [15:0]      wdata_i,
  output var  logic             ack_o,
  output var  logic [15:0]      rdata_o,
  output var  logic [7:0]       resp_code_o,
  output var  logic [7:0]       err_code_o,
  // Per-axis monitor values from the motor control
  input  wire logic [2:0][15:0] zero_offset_u_i,
  input  wire logic [2:0][15:0] zero_offset_v_i,
  input  wire logic [2:0][15:0] speed_rpm_i,
  input  wire logic [2:0][15:0] torque_percent_i,
  input  wire logic [2:0][31:0] encoder_pulses_i,
  input  wire logic [2:0][15:0] input_lower_i,
  input  wire logic [2:0][15:0] input_upper_i,
  input  wire logic [2:0][15:0] output_levels_i,
  input  wire logic [2:0][15:0] reference_pulse_i,
  input  wire logic [2:0][31:0] position_i,
  input  wire logic [2:0][31:0] following_error_i,
  input  wire logic [2:0][31:0] commanded_pulses_i,
  input  wire logic [2:0][15:0] inertia_percent_i,
  input  wire logic [2:0][15:0] overload_percent_i,
  // New alarm events, one-cycle pulse per axis
  input  wire logic [2:0]       alarm_push_i,
  input  wire logic [2:0][15:0] alarm_code_i,
  // Live gear ratio to the position loop
  output var  logic [2:0][15:0] gear_divisor_o,
  output var  logic [2:0][15:0] gear_mult_first_o,
  output var  logic [2:0][15:0] gear_mult_second_o,
  output var  logic [2:0][15:0] gear_divisor_upper_o
);

  // ****************************************************
  // State
  // ****************************************************
  typedef struct packed {
    logic                   ack;
    logic [15:0]            rdata;
    logic [7:0]             resp;
    logic [7:0]             err;
    logic [2:0][15:0]       gear_div;
    logic [2:0][15:0]       gear_mul1;
    logic [2:0][15:0]       gear_mul2;
    logic [2:0][15:0]       gear_div_hi;
    logic [2:0][9:0][15:0]  alarm;
    logic [2:0][3:0][15:0]  snap_hi;
  } map_state_t;

  map_state_t q;
  map_state_t next_q;

  // Parameter store has no reset; it is RAM filled by the host
  logic [15:0] param_mem [0:servo_axis_map_pkg::AXES * servo_axis_map_pkg::PARAM_WORDS - 1];

  logic              axis_ok;
  logic [1:0]        axis;
  logic [12:0]       ofs;
  logic [11:0]       param_idx;
  logic              in_param;
  logic              param_we;
  logic signed [31:0] pos_sel;
  logic signed [31:0] cmd_sel;
  logic signed [31:0] pos_quot;
  logic signed [31:0] pos_rem;
  logic signed [31:0] cmd_quot;
  logic signed [31:0] cmd_rem;

  // ****************************************************
  // Address decode
  // ****************************************************
  assign axis_ok   = addr_i[15:13] <= servo_axis_map_pkg::AXIS_C_SEL;
  assign axis      = axis_ok ? addr_i[14:13] : 2'h0;
  assign ofs       = addr_i[12:0];
  assign in_param  = axis_ok && (ofs <= servo_axis_map_pkg::PARAM_LAST);
  assign param_idx = ({10'h000, axis} * servo_axis_map_pkg::PARAM_WORDS) + ofs[11:0];
  assign param_we  = req_i && write_i && in_param;

  // Signed split into single pulses and ten-thousands
  assign pos_sel  = $signed(position_i[axis]);
  assign cmd_sel  = $signed(commanded_pulses_i[axis]);
  assign pos_quot = pos_sel / servo_axis_map_pkg::PULSES_PER_HIGH;
  assign pos_rem  = pos_sel % servo_axis_map_pkg::PULSES_PER_HIGH;
  assign cmd_quot = cmd_sel / servo_axis_map_pkg::PULSES_PER_HIGH;
  assign cmd_rem  = cmd_sel % servo_axis_map_pkg::PULSES_PER_HIGH;

  // ****************************************************
  // Next state
  // ****************************************************
  always_comb begin
    logic        hit;
    logic        ro;
    logic [15:0] rd;
    hit    = 1'b0;
    ro     = 1'b1;
    rd     = 16'h0000;
    next_q = q;
    next_q.ack = 1'b0;

    // Newest alarm enters record 0, oldest falls off the end
    for (int a = 0; a < servo_axis_map_pkg::AXES; a++) begin
      if (alarm_push_i[a]) begin
        next_q.alarm[a] = {q.alarm[a][8:0], alarm_code_i[a]};
      end
    end

    if (req_i) begin
      if (in_param) begin
        hit = 1'b1;
        ro  = 1'b0;
        rd  = param_mem[param_idx];
      end else if (axis_ok && ofs >= servo_axis_map_pkg::ALARM_FIRST &&
                   ofs <= servo_axis_map_pkg::ALARM_LAST) begin
        hit = 1'b1;
        rd  = q.alarm[axis][4'(ofs - servo_axis_map_pkg::ALARM_FIRST)];
      end else if (axis_ok) begin
        // Unlisted words inside the monitor window read as zero
        hit = (ofs >= servo_axis_map_pkg::MONITOR_FIRST) &&
              (ofs <= servo_axis_map_pkg::MONITOR_LAST);
        case (ofs)
          servo_axis_map_pkg::OFS_ZERO_U: begin
            hit = 1'b1;
            rd  = zero_offset_u_i[axis];
          end
          servo_axis_map_pkg::OFS_ZERO_V: begin
            hit = 1'b1;
            rd  = zero_offset_v_i[axis];
          end
          servo_axis_map_pkg::OFS_SPEED: begin
            rd = speed_rpm_i[axis];
          end
          servo_axis_map_pkg::OFS_TORQUE: begin
            rd = torque_percent_i[axis];
          end
          servo_axis_map_pkg::OFS_ENC_LOW: begin
            rd = encoder_pulses_i[axis][15:0];
            // A refused write to a low word leaves the pair's latch alone
            if (!write_i) begin
              next_q.snap_hi[axis][servo_axis_map_pkg::SNAP_ENC] =
                encoder_pulses_i[axis][31:16];
            end
          end
          servo_axis_map_pkg::OFS_ENC_HIGH: begin
            rd = q.snap_hi[axis][servo_axis_map_pkg::SNAP_ENC];
          end
          servo_axis_map_pkg::OFS_IN_LOWER: begin
            rd = input_lower_i[axis];
          end
          servo_axis_map_pkg::OFS_IN_UPPER: begin
            rd = input_upper_i[axis];
          end
          servo_axis_map_pkg::OFS_OUT_LEVELS: begin
            rd = output_levels_i[axis];
          end
          servo_axis_map_pkg::OFS_REF_PULSE: begin
            rd = reference_pulse_i[axis];
          end
          servo_axis_map_pkg::OFS_POS_UNITS: begin
            rd = pos_rem[15:0];
            if (!write_i) begin
              next_q.snap_hi[axis][servo_axis_map_pkg::SNAP_POS] = pos_quot[15:0];
            end
          end
          servo_axis_map_pkg::OFS_POS_TENK: begin
            rd = q.snap_hi[axis][servo_axis_map_pkg::SNAP_POS];
          end
          servo_axis_map_pkg::OFS_FERR_LOW: begin
            rd = following_error_i[axis][15:0];
            if (!write_i) begin
              next_q.snap_hi[axis][servo_axis_map_pkg::SNAP_FERR] =
                following_error_i[axis][31:16];
            end
          end
          servo_axis_map_pkg::OFS_FERR_HIGH: begin
            rd = q.snap_hi[axis][servo_axis_map_pkg::SNAP_FERR];
          end
          servo_axis_map_pkg::OFS_CMD_UNITS: begin
            hit = 1'b1;
            rd  = cmd_rem[15:0];
            if (!write_i) begin
              next_q.snap_hi[axis][servo_axis_map_pkg::SNAP_CMD] = cmd_quot[15:0];
            end
          end
          servo_axis_map_pkg::OFS_CMD_TENK: begin
            hit = 1'b1;
            rd  = q.snap_hi[axis][servo_axis_map_pkg::SNAP_CMD];
          end
          servo_axis_map_pkg::OFS_INERTIA: begin
            hit = 1'b1;
            rd  = inertia_percent_i[axis];
          end
          servo_axis_map_pkg::OFS_OVERLOAD: begin
            hit = 1'b1;
            rd  = overload_percent_i[axis];
          end
          servo_axis_map_pkg::OFS_GEAR_DIV: begin
            hit = 1'b1;
            ro  = 1'b0;
            rd  = q.gear_div[axis];
            if (write_i) next_q.gear_div[axis] = wdata_i;
          end
          servo_axis_map_pkg::OFS_GEAR_MUL1: begin
            hit = 1'b1;
            ro  = 1'b0;
            rd  = q.gear_mul1[axis];
            if (write_i) next_q.gear_mul1[axis] = wdata_i;
          end
          servo_axis_map_pkg::OFS_GEAR_MUL2: begin
            hit = 1'b1;
            ro  = 1'b0;
            rd  = q.gear_mul2[axis];
            if (write_i) next_q.gear_mul2[axis] = wdata_i;
          end
          servo_axis_map_pkg::OFS_GEAR_DIV_HI: begin
            hit = 1'b1;
            ro  = 1'b0;
            rd  = q.gear_div_hi[axis];
            if (write_i) next_q.gear_div_hi[axis] = wdata_i;
          end
          default: begin
          end
        endcase
      end

      // Writes echo the data, as the frame engine returns it unchanged
      next_q.ack   = 1'b1;
      next_q.rdata = write_i ? wdata_i : rd;
      if (!hit) begin
        next_q.err  = servo_axis_map_pkg::ERR_NO_ADDRESS;
        next_q.resp = cmd_i + servo_axis_map_pkg::ERROR_FLAG;
      end else if (write_i && ro) begin
        next_q.err  = servo_axis_map_pkg::ERR_NOT_DONE;
        next_q.resp = cmd_i + servo_axis_map_pkg::ERROR_FLAG;
      end else begin
        next_q.err  = servo_axis_map_pkg::ERR_NONE;
        next_q.resp = cmd_i;
      end
      // Unmapped answers carry no data
      if (!hit) next_q.rdata = 16'h0000;
    end
  end

  // ****************************************************
  // Registers
  // ****************************************************
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q             <= '0;
      // Restart drops host-written gear values
      q.gear_div    <= {3{GEAR_DIV_DEFAULT}};
      q.gear_mul1   <= {3{GEAR_MUL1_DEFAULT}};
      q.gear_mul2   <= {3{GEAR_MUL2_DEFAULT}};
      q.gear_div_hi <= {3{GEAR_DIV_HI_DEFAULT}};
    end else begin
      q <= next_q;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (param_we) begin
      param_mem[param_idx] <= wdata_i;
    end
  end

  assign ack_o                = q.ack;
  assign rdata_o              = q.rdata;
  assign resp_code_o          = q.resp;
  assign err_code_o           = q.err;
  assign gear_divisor_o       = q.gear_div;
  assign gear_mult_first_o    = q.gear_mul1;
  assign gear_mult_second_o   = q.gear_mul2;
  assign gear_divisor_upper_o = q.gear_div_hi;

endmodule

`default_nettype wire

/* File: servo_axis_modbus_register_map_tb_top.sv */
// Self-checking bench for the three-axis servo data map.
`default_nettype none
module servo_axis_modbus_register_map_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic w; logic [15:0] a; logic [15:0] d; logic [15:0] r; logic [7:0] e;}
    row_t;
  logic             clk_sys_i = 1'b0;
  logic             rst_n_i = 1'b1;
  logic             req, wr, ack;
  logic [7:0]       cmd, resp, err;
  logic [15:0]      addr, wdata, rdata;
  logic [2:0]       apush = 3'h0;
  logic [2:0][15:0] u, v, spd, trq, inl, inh, outl, refp, iner, ovl, acode, gdiv, gm1, gm2, gdh;
  logic [2:0][31:0] enc, pos, ferr, cmdp;
  int               fails = 0;
  int               n_tests = 0;
  int               cyc = 0;
  row_t             rows [29] = '{
    '{1'b0, 16'h27fe, 16'h0000, 16'h0201, 8'h00}, '{1'b0, 16'h4806, 16'h0000, 16'h0302, 8'h00},
    '{1'b0, 16'h080a, 16'h0000, 16'h5678, 8'h00}, '{1'b0, 16'h080b, 16'h0000, 16'h1234, 8'h00},
    '{1'b0, 16'h280c, 16'h0000, 16'h0501, 8'h00}, '{1'b0, 16'h080d, 16'h0000, 16'h0600, 8'h00},
    '{1'b0, 16'h480e, 16'h0000, 16'h0702, 8'h00}, '{1'b0, 16'h0810, 16'h0000, 16'h0d80, 8'h00},
    '{1'b0, 16'h0811, 16'h0000, 16'h000c, 8'h00}, '{1'b0, 16'h2810, 16'h0000, 16'hf280, 8'h00},
    '{1'b0, 16'h2811, 16'h0000, 16'hfff4, 8'h00}, '{1'b0, 16'h0818, 16'h0000, 16'h0001, 8'h00},
    '{1'b0, 16'h0819, 16'h0000, 16'h0007, 8'h00}, '{1'b0, 16'h0815, 16'h0000, 16'h0000, 8'h00},
    '{1'b0, 16'h081d, 16'h0000, 16'h0a00, 8'h00}, '{1'b0, 16'h0817, 16'h0000, 16'h0000, 8'h02},
    '{1'b1, 16'h0066, 16'h1388, 16'h1388, 8'h00}, '{1'b1, 16'h2066, 16'h5555, 16'h5555, 8'h00},
    '{1'b0, 16'h0066, 16'h0000, 16'h1388, 8'h00}, '{1'b1, 16'h4369, 16'h00aa, 16'h00aa, 8'h00},
    '{1'b0, 16'h4369, 16'h0000, 16'h00aa, 8'h00}, '{1'b0, 16'h436a, 16'h0000, 16'h0000, 8'h02},
    '{1'b0, 16'h6000, 16'h0000, 16'h0000, 8'h02}, '{1'b1, 16'h0806, 16'h0001, 16'h0000, 8'h04},
    '{1'b1, 16'h0827, 16'h0001, 16'h0000, 8'h04}, '{1'b1, 16'h0850, 16'h0007, 16'h0007, 8'h00},
    '{1'b1, 16'h2851, 16'h0009, 16'h0009, 8'h00}, '{1'b1, 16'h4852, 16'h000b, 16'h000b, 8'h00},
    '{1'b1, 16'h0853, 16'h0003, 16'h0003, 8'h00}};

  always #20 clk_sys_i = ~clk_sys_i;

  servo_axis_modbus_register_map DUT (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .req_i(req),
    .write_i(wr), .cmd_i(cmd), .addr_i(addr), .wdata_i(wdata), .ack_o(ack), .rdata_o(rdata),
    .resp_code_o(resp), .err_code_o(err), .zero_offset_u_i(u), .zero_offset_v_i(v),
    .speed_rpm_i(spd), .torque_percent_i(trq), .encoder_pulses_i(enc), .input_lower_i(inl),
    .input_upper_i(inh), .output_levels_i(outl), .reference_pulse_i(refp), .position_i(pos),
    .following_error_i(ferr), .commanded_pulses_i(cmdp), .inertia_percent_i(iner),
    .overload_percent_i(ovl), .alarm_push_i(apush), .alarm_code_i(acode),
    .gear_divisor_o(gdiv), .gear_mult_first_o(gm1), .gear_mult_second_o(gm2),
    .gear_divisor_upper_o(gdh));
  servo_host_model host (.clk_sys_i(clk_sys_i), .ack_i(ack), .rdata_i(rdata), .resp_i(resp),
    .err_i(err), .req_o(req), .write_o(wr), .cmd_o(cmd), .addr_o(addr), .wdata_o(wdata));

  task automatic check(string nm, logic [15:0] seen, logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic rw(input row_t t);
    logic [15:0] rd;
    logic [7:0]  rc, ec, rx;
    logic        ak;
    host.xfer(t.w, t.a, t.d, rd, rc, ec, ak);
    rx = (t.w ? 8'h06 : 8'h03) + (t.e != 8'h00 ? 8'h80 : 8'h00);
    check("ack", {15'h0000, ak}, 16'h0001);
    if (t.e != 8'h04) begin
      check("rdata", rd, t.r);
    end
    check("err", {8'h00, ec}, {8'h00, t.e});
    check("resp", {8'h00, rc}, {8'h00, rx});
  endtask

  task automatic do_reset();
    rst_n_i = 1'b0;
    repeat (6) @(negedge clk_sys_i);
    rst_n_i = 1'b1;
  endtask

  // Hang guard, far above the roughly 111 cycles the run needs
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      tally_and_finish();
    end
  end

  initial begin
    for (int n = 0; n < 3; n++) begin
      u[n] = 16'h0100 + 16'(n);
      v[n] = 16'h0200 + 16'(n);
      spd[n] = 16'h0300 + 16'(n);
      trq[n] = 16'h0400 + 16'(n);
      inl[n] = 16'h0500 + 16'(n);
      inh[n] = 16'h0600 + 16'(n);
      outl[n] = 16'h0700 + 16'(n);
      refp[n] = 16'h0800 + 16'(n);
      iner[n] = 16'h0900 + 16'(n);
      ovl[n] = 16'h0a00 + 16'(n);
      acode[n] = 16'h0000;
      enc[n] = 32'h12345678 + 32'(n);
      ferr[n] = 32'habcd0001;
      pos[n] = 32'h0001e240;
      cmdp[n] = 32'h00011171;
    end
    pos[1] = 32'hfffe1dc0;
    // Falling reset after time zero, so the asynchronous branch sees an edge
    #1;
    do_reset();
    check("gear div", gdiv[0], 16'h0001);
    foreach (rows[i]) rw(rows[i]);
    check("gear div", gdiv[0], 16'h0007);
    check("gear mul1", gm1[1], 16'h0009);
    check("gear mul2", gm2[2], 16'h000b);
    check("gear div hi", gdh[0], 16'h0003);
    check("gear div b", gdiv[1], 16'h0001);
    for (int k = 0; k < 11; k++) begin
      apush = 3'h1;
      acode[0] = 16'h0c00 + 16'(k);
      @(negedge clk_sys_i);
    end
    apush = 3'h0;
    rw('{1'b0, 16'h081e, 16'h0000, 16'h0c0a, 8'h00});
    rw('{1'b0, 16'h0827, 16'h0000, 16'h0c01, 8'h00});
    rw('{1'b0, 16'h281e, 16'h0000, 16'h0000, 8'h00});
    rw('{1'b0, 16'h080a, 16'h0000, 16'h5678, 8'h00});
    enc[0] = 32'h99990000;
    rw('{1'b0, 16'h080b, 16'h0000, 16'h1234, 8'h00});
    rw('{1'b1, 16'h080a, 16'h0001, 16'h0000, 8'h04});
    rw('{1'b0, 16'h080b, 16'h0000, 16'h1234, 8'h00});
    rw('{1'b0, 16'h480d, 16'h0000, 16'h0602, 8'h00});
    rw('{1'b0, 16'h4810, 16'h0000, 16'h0d80, 8'h00});
    rw('{1'b0, 16'h4811, 16'h0000, 16'h000c, 8'h00});
    rw('{1'b0, 16'h4818, 16'h0000, 16'h0001, 8'h00});
    rw('{1'b0, 16'h4819, 16'h0000, 16'h0007, 8'h00});
    rw('{1'b0, 16'h2814, 16'h0000, 16'h0001, 8'h00});
    rw('{1'b0, 16'h2815, 16'h0000, 16'habcd, 8'h00});
    do_reset();
    check("gear div", gdiv[0], 16'h0001);
    check("gear div hi", gdh[0], 16'h0000);
    rw('{1'b0, 16'h0850, 16'h0000, 16'h0001, 8'h00});
    tally_and_finish();
  end
endmodule
`default_nettype wire

/* File: servo_host_model.sv */
// Host controller model issuing single word requests to the data map.
`default_nettype none
module servo_host_model (
  input  wire logic        clk_sys_i,
  input  wire logic        ack_i,
  input  wire logic [15:0] rdata_i,
  input  wire logic [7:0]  resp_i,
  input  wire logic [7:0]  err_i,
  output var  logic        req_o,
  output var  logic        write_o,
  output var  logic [7:0]  cmd_o,
  output var  logic [15:0] addr_o,
  output var  logic [15:0] wdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    req_o = 1'b0;
    write_o = 1'b0;
    cmd_o = 8'h00;
    addr_o = 16'hffff;
    wdata_o = 16'h0000;
  end
  // Released lines go inverse so a stale request never looks valid
  task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d,
                      output logic [15:0] rd, output logic [7:0] rc, output logic [7:0] ec,
                      output logic ak);
    @(negedge clk_sys_i);
    req_o = 1'b1;
    write_o = w;
    cmd_o = w ? 8'h06 : 8'h03;
    addr_o = a;
    wdata_o = d;
    @(negedge clk_sys_i);
    ak = ack_i;
    rd = rdata_i;
    rc = resp_i;
    ec = err_i;
    req_o = 1'b0;
    write_o = ~w;
    cmd_o = ~cmd_o;
    addr_o = ~a;
    wdata_o = ~d;
  endtask
endmodule
`default_nettype wire
